// ===== common/ectl_map.svh
`ifndef ECTL_MAP_SVH
`define ECTL_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ECTL_CTRL_OFS        8'h00
`define ECTL_SPDIV_OFS       8'h04
`define ECTL_STAT_OFS        8'h08
`define ECTL_SCNT_OFS        8'h0C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define ECTL_CTRL_SMPL_EN    0
`define ECTL_CTRL_SMPL_RISE  1
`define ECTL_CTRL_TOUT_LVL   2
`define ECTL_CTRL_FILT_EN    3
`define ECTL_CTRL_TIN_FALL   4
`define ECTL_CTRL_TIN_STOP   5
`define ECTL_CTRL_PASS_LSB   6
`define ECTL_CTRL_FAIL_LSB   8
`define ECTL_CTRL_W          10
`define ECTL_CTRL_RST        10'h000

// ----------------------------------------
// samples per division and status
// ----------------------------------------
`define ECTL_SPDIV_W         10
`define ECTL_SPDIV_MIN       10'h00A
`define ECTL_SPDIV_MAX       10'h3E8
`define ECTL_SPDIV_RST       10'h064
`define ECTL_STAT_REJ        8
`define ECTL_STAT_REFUSE     9

// ----------------------------------------
// timing
// ----------------------------------------
`define ECTL_CLK_KHZ         250000
`define ECTL_CLK_MHZ         250
`define ECTL_TPULSE_MS       2
`define ECTL_TPULSE_CYC      (`ECTL_TPULSE_MS * `ECTL_CLK_KHZ)
`define ECTL_TLVL_MIN_US     2
`define ECTL_TLVL_MIN_CYC    (`ECTL_TLVL_MIN_US * `ECTL_CLK_MHZ)
`define ECTL_FILT_MS         2
`define ECTL_FILT_CYC        (`ECTL_FILT_MS * `ECTL_CLK_KHZ)
`define ECTL_TMR_W           20

`endif

// ===== common/ectl_pkg.sv
package ectl_pkg;
  typedef enum logic [1:0] {
    stat_judge,
    stat_error,
    stat_busy,
    stat_wait_trig
  } ectl_stat_mode_e;

  typedef enum logic [1:0] {
    tout_idle,
    tout_pulse,
    tout_level
  } ectl_tout_state_e;
endpackage : ectl_pkg

// ===== verilog/ectl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ectl_sync (
  input  wire logic mclk_in,
  input  wire logic nrst_in,
  input  wire logic pin_in,
  output var  logic level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_ff;
  logic prev_ff;

  // only the second stage looks at meta_ff
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff   <= 1'b1;
      level_out <= 1'b1;
      prev_ff   <= 1'b1;
    end else begin
      meta_ff   <= pin_in;
      level_out <= meta_ff;
      prev_ff   <= level_out;
    end
  end

  assign rise_out = level_out & ~prev_ff;
  assign fall_out = ~level_out & prev_ff;
endmodule : ectl_sync
`default_nettype wire

// ===== verilog/ectl_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ectl_map.svh"
module ectl_timer (
  input  wire logic                    mclk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    load_in,
  input  wire logic [`ECTL_TMR_W-1:0]  len_in,
  output var  logic                    busy_out
);
  logic [`ECTL_TMR_W-1:0] cnt_ff;

  // busy stays high for exactly len_in cycles after the load
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff   <= '0;
      busy_out <= 1'b0;
    end else if (load_in) begin
      cnt_ff   <= len_in;
      busy_out <= 1'b1;
    end else if (busy_out) begin
      cnt_ff   <= cnt_ff - 1'b1;
      busy_out <= (cnt_ff != 20'h00001);
    end
  end
endmodule : ectl_timer
`default_nettype wire

// ===== verilog/ectl_top.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ectl_map.svh"

// Functional notes
// - judge mode: pass output pulls low when the judgment result is pass.
// - judge mode: fail output pulls low when the judgment result is fail.
// - error mode: the output pulls low while the instrument reports an error.
// - busy mode: the output pulls low while external start is not accepted.
// - wait mode: the output pulls low while armed and waiting for trigger.
// - status and trigger outputs are active-low open-drain.
// - status outputs rest high while their condition is not met.
// - external sampling cannot be enabled while real-time saving is on.
// - one sample per selected edge of the sample input, falling by default.
// - samples per division accepted 10 to 1000, default 100, others rejected.
// - numerical calculation monitor is off while external sampling is active.
// - pulse mode: trigger output low for 2 ms after a trigger.
// - level mode: trigger output low until acquisition ends, at least 2 us.
// - trigger output fires during measurement even with no trigger set up.
// - auto-range triggers also fire the trigger output.
// - external trigger input serves as start or stop trigger as configured.
// - external trigger event on the configured rising or falling edge.
// - optional filter needs the trigger level held for an interval, default off.
module ectl_top #(
  parameter logic [`ECTL_TMR_W-1:0] TPULSE_CYC = `ECTL_TMR_W'(`ECTL_TPULSE_CYC),
  parameter logic [`ECTL_TMR_W-1:0] FILT_CYC   = `ECTL_TMR_W'(`ECTL_FILT_CYC)
) (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output var  logic [31:0] rdata_out,
  input  wire logic        judge_valid_in,
  input  wire logic        judge_pass_in,
  input  wire logic        error_in,
  input  wire logic        busy_in,
  input  wire logic        armed_in,
  input  wire logic        acq_active_in,
  input  wire logic        trig_event_in,
  input  wire logic        autorange_trig_in,
  input  wire logic        realtime_save_in,
  input  wire logic        pass_status_in,
  output var  logic        pass_status_out,
  output var  logic        pass_status_oe_out,
  input  wire logic        fail_status_in,
  output var  logic        fail_status_out,
  output var  logic        fail_status_oe_out,
  input  wire logic        trigger_in,
  output var  logic        trigger_out,
  output var  logic        trigger_oe_out,
  input  wire logic        external_sample_clock_input_in,
  input  wire logic        external_trigger_input_in,
  output var  logic        sample_strobe_out,
  output var  logic        ext_sample_active_out,
  output var  logic        calc_monitor_en_out,
  output var  logic        ext_start_trigger_output,
  output var  logic        ext_stop_trigger_output
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic stat_cond(input ectl_pkg::ectl_stat_mode_e mode,
                                     input logic judge_hit);
    case (mode)
      ectl_pkg::stat_judge:     stat_cond = judge_hit;
      ectl_pkg::stat_error:     stat_cond = error_in;
      ectl_pkg::stat_busy:      stat_cond = busy_in;
      ectl_pkg::stat_wait_trig: stat_cond = armed_in;
      default:                  stat_cond = 1'b0;
    endcase
  endfunction : stat_cond

  function automatic logic hit(input logic [7:0] ofs);
    hit = (addr_in == ofs);
  endfunction : hit

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [`ECTL_CTRL_W-1:0]  ctrl_ff;
  logic [`ECTL_SPDIV_W-1:0] spdiv_ff;
  logic                     rej_ff;
  logic                     refuse_ff;
  logic [31:0]              scnt_ff;
  logic [`ECTL_SPDIV_W-1:0] wr_spdiv;
  logic                     wr_ctrl;
  logic                     wr_spdiv_ok;
  logic                     smpl_refused;

  ectl_pkg::ectl_stat_mode_e pass_mode;
  ectl_pkg::ectl_stat_mode_e fail_mode;

  assign pass_mode    = ectl_pkg::ectl_stat_mode_e'(ctrl_ff[`ECTL_CTRL_PASS_LSB +: 2]);
  assign fail_mode    = ectl_pkg::ectl_stat_mode_e'(ctrl_ff[`ECTL_CTRL_FAIL_LSB +: 2]);
  assign wr_ctrl      = wr_in & hit(`ECTL_CTRL_OFS);
  assign wr_spdiv     = wdata_in[`ECTL_SPDIV_W-1:0];
  assign wr_spdiv_ok  = (wdata_in[31:`ECTL_SPDIV_W] == '0) && (wr_spdiv >= `ECTL_SPDIV_MIN)
                        && (wr_spdiv <= `ECTL_SPDIV_MAX);
  assign smpl_refused = wr_ctrl & wdata_in[`ECTL_CTRL_SMPL_EN] & realtime_save_in;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_ff <= `ECTL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= wdata_in[`ECTL_CTRL_W-1:0];
      ctrl_ff[`ECTL_CTRL_SMPL_EN] <= wdata_in[`ECTL_CTRL_SMPL_EN] & ~realtime_save_in;
    end
  end

  // out-of-range values leave the old setting in place
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      spdiv_ff <= `ECTL_SPDIV_RST;
    end else if (wr_in && hit(`ECTL_SPDIV_OFS) && wr_spdiv_ok) begin
      spdiv_ff <= wr_spdiv;
    end
  end

  // sticky flags: a new event beats a clearing write in the same cycle
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rej_ff    <= 1'b0;
      refuse_ff <= 1'b0;
    end else begin
      if (wr_in && hit(`ECTL_SPDIV_OFS) && !wr_spdiv_ok) begin
        rej_ff <= 1'b1;
      end else if (wr_in && hit(`ECTL_STAT_OFS) && wdata_in[`ECTL_STAT_REJ]) begin
        rej_ff <= 1'b0;
      end
      if (smpl_refused) begin
        refuse_ff <= 1'b1;
      end else if (wr_in && hit(`ECTL_STAT_OFS) && wdata_in[`ECTL_STAT_REFUSE]) begin
        refuse_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // external sampling
  // ----------------------------------------
  logic smpl_level;
  logic smpl_rise;
  logic smpl_fall;
  logic smpl_edge;
  logic smpl_active;

  ectl_sync u_smpl_sync (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .pin_in    (external_sample_clock_input_in),
    .level_out (smpl_level),
    .rise_out  (smpl_rise),
    .fall_out  (smpl_fall)
  );

  // saving switched on later also stops sampling at once
  assign smpl_active = ctrl_ff[`ECTL_CTRL_SMPL_EN] & ~realtime_save_in;
  assign smpl_edge   = ctrl_ff[`ECTL_CTRL_SMPL_RISE] ? smpl_rise : smpl_fall;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sample_strobe_out     <= 1'b0;
      ext_sample_active_out <= 1'b0;
      calc_monitor_en_out   <= 1'b1;
    end else begin
      sample_strobe_out     <= smpl_active & smpl_edge;
      ext_sample_active_out <= smpl_active;
      calc_monitor_en_out   <= ~smpl_active;
    end
  end

  // every sample strobe counts one point, so N points need N edges
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scnt_ff <= '0;
    end else if (wr_in && hit(`ECTL_SCNT_OFS)) begin
      scnt_ff <= '0;
    end else if (sample_strobe_out) begin
      scnt_ff <= scnt_ff + 32'h00000001;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pass_status_oe_out <= 1'b0;
      fail_status_oe_out <= 1'b0;
    end else begin
      pass_status_oe_out <= stat_cond(pass_mode, judge_valid_in & judge_pass_in);
      fail_status_oe_out <= stat_cond(fail_mode, judge_valid_in & ~judge_pass_in);
    end
  end

  // open drain: the data bit is always low, only the enable moves
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pass_status_out <= 1'b0;
      fail_status_out <= 1'b0;
      trigger_out     <= 1'b0;
    end else begin
      pass_status_out <= 1'b0;
      fail_status_out <= 1'b0;
      trigger_out     <= 1'b0;
    end
  end

  // ----------------------------------------
  // trigger output
  // ----------------------------------------
  ectl_pkg::ectl_tout_state_e tout_ff;
  ectl_pkg::ectl_tout_state_e nxt_tout;
  logic                       tout_fire;
  logic                       tmr_load;
  logic                       tmr_busy;
  logic [`ECTL_TMR_W-1:0]     tmr_len;

  assign tout_fire = trig_event_in | autorange_trig_in;
  assign tmr_load  = (tout_ff == ectl_pkg::tout_idle) & tout_fire;
  assign tmr_len   = ctrl_ff[`ECTL_CTRL_TOUT_LVL] ? `ECTL_TMR_W'(`ECTL_TLVL_MIN_CYC) : TPULSE_CYC;

  ectl_timer u_tout_timer (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .load_in  (tmr_load),
    .len_in   (tmr_len),
    .busy_out (tmr_busy)
  );

  always_comb begin
    nxt_tout = tout_ff;
    case (tout_ff)
      ectl_pkg::tout_idle: begin
        if (tout_fire) begin
          nxt_tout = ctrl_ff[`ECTL_CTRL_TOUT_LVL] ? ectl_pkg::tout_level : ectl_pkg::tout_pulse;
        end
      end
      ectl_pkg::tout_pulse: begin
        if (!tmr_busy) begin
          nxt_tout = ectl_pkg::tout_idle;
        end
      end
      // held for acquisition, never shorter than the minimum
      ectl_pkg::tout_level: begin
        if (!tmr_busy && !acq_active_in) begin
          nxt_tout = ectl_pkg::tout_idle;
        end
      end
      default: nxt_tout = ectl_pkg::tout_idle;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tout_ff        <= ectl_pkg::tout_idle;
      trigger_oe_out <= 1'b0;
    end else begin
      tout_ff        <= nxt_tout;
      trigger_oe_out <= (nxt_tout != ectl_pkg::tout_idle);
    end
  end

  // ----------------------------------------
  // external trigger input
  // ----------------------------------------
  logic                   tin_level;
  logic                   tin_rise;
  logic                   tin_fall;
  logic                   filt_ff;
  logic                   filt_prev_ff;
  logic [`ECTL_TMR_W-1:0] filt_cnt_ff;
  logic                   tin_edge;
  logic                   filt_edge;

  ectl_sync u_tin_sync (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .pin_in    (external_trigger_input_in),
    .level_out (tin_level),
    .rise_out  (tin_rise),
    .fall_out  (tin_fall)
  );

  // a new level is taken only once it has stood for the whole interval
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      filt_ff     <= 1'b1;
      filt_cnt_ff <= '0;
    end else if (tin_level == filt_ff) begin
      filt_cnt_ff <= '0;
    end else if (filt_cnt_ff == FILT_CYC - 1'b1) begin
      filt_ff     <= tin_level;
      filt_cnt_ff <= '0;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      filt_prev_ff <= 1'b1;
    end else begin
      filt_prev_ff <= filt_ff;
    end
  end

  assign filt_edge = ctrl_ff[`ECTL_CTRL_TIN_FALL] ? (filt_prev_ff & ~filt_ff) : (~filt_prev_ff & filt_ff);
  assign tin_edge  = ctrl_ff[`ECTL_CTRL_FILT_EN] ? filt_edge
                   : (ctrl_ff[`ECTL_CTRL_TIN_FALL] ? tin_fall : tin_rise);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_start_trigger_output <= 1'b0;
      ext_stop_trigger_output  <= 1'b0;
    end else begin
      ext_start_trigger_output <= tin_edge & ~ctrl_ff[`ECTL_CTRL_TIN_STOP];
      ext_stop_trigger_output  <= tin_edge & ctrl_ff[`ECTL_CTRL_TIN_STOP];
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      case (addr_in)
        `ECTL_CTRL_OFS:  rdata_out <= {22'h000000, ctrl_ff};
        `ECTL_SPDIV_OFS: rdata_out <= {22'h000000, spdiv_ff};
        `ECTL_STAT_OFS:  rdata_out <= {22'h000000, refuse_ff, rej_ff, 1'b0, trigger_in,
                                       fail_status_in, pass_status_in, filt_ff, trigger_oe_out,
                                       calc_monitor_en_out, ext_sample_active_out};
        `ECTL_SCNT_OFS:  rdata_out <= scnt_ff;
        default:         rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [`ECTL_TMR_W-1:0] low_len_ff;
  logic                   lvl_run_ff;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_len_ff <= '0;
      lvl_run_ff <= 1'b0;
    end else if (trigger_oe_out) begin
      low_len_ff <= low_len_ff + 1'b1;
    end else begin
      low_len_ff <= '0;
      lvl_run_ff <= ctrl_ff[`ECTL_CTRL_TOUT_LVL];
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  a_pass_judge: assert property (pass_mode == ectl_pkg::stat_judge && judge_valid_in && judge_pass_in
    |=> pass_status_oe_out) else $error("pass output not low on pass");
  a_fail_judge: assert property (fail_mode == ectl_pkg::stat_judge && judge_valid_in && !judge_pass_in
    |=> fail_status_oe_out) else $error("fail output not low on fail");
  a_error_mode: assert property (pass_mode == ectl_pkg::stat_error && error_in
    |=> pass_status_oe_out) else $error("error mode output not low");
  a_busy_mode: assert property (fail_mode == ectl_pkg::stat_busy && busy_in
    |=> fail_status_oe_out) else $error("busy mode output not low");
  a_wait_mode: assert property (pass_mode == ectl_pkg::stat_wait_trig && armed_in
    |=> pass_status_oe_out) else $error("wait mode output not low");
  a_od_drive: assert property (!pass_status_out && !fail_status_out && !trigger_out)
    else $error("open drain output driven high");
  a_rest_high: assert property (pass_mode == ectl_pkg::stat_error && !error_in
    |=> !pass_status_oe_out) else $error("status output low without cause");
  a_smpl_refuse: assert property (smpl_refused |=> !ext_sample_active_out && refuse_ff)
    else $error("sampling enabled during real-time save");
  a_smpl_strobe: assert property (sample_strobe_out |-> $past(smpl_active))
    else $error("sample strobe while sampling inactive");
  a_spdiv_range: assert property (spdiv_ff >= `ECTL_SPDIV_MIN && spdiv_ff <= `ECTL_SPDIV_MAX)
    else $error("samples per division out of range");
  a_calc_mon: assert property (ext_sample_active_out |-> !calc_monitor_en_out)
    else $error("calculation monitor on during external sampling");
  a_pulse_len: assert property ($fell(trigger_oe_out) && !lvl_run_ff
    |-> $past(low_len_ff) >= TPULSE_CYC && $past(low_len_ff) <= TPULSE_CYC + 20'h00002)
    else $error("trigger pulse width wrong");
  a_level_min: assert property ($fell(trigger_oe_out) && lvl_run_ff
    |-> $past(low_len_ff) >= `ECTL_TLVL_MIN_CYC && !$past(acq_active_in))
    else $error("level trigger output ended early");
  a_fire_out: assert property (tout_ff == ectl_pkg::tout_idle && tout_fire
    |=> trigger_oe_out [*2]) else $error("trigger output missed a trigger");
  a_tin_route: assert property (ext_start_trigger_output |-> !ext_stop_trigger_output && !$past(ctrl_ff[5]))
    else $error("external trigger routed to wrong role");

  c_pulse_done: cover property ($fell(trigger_oe_out) && !lvl_run_ff);
  c_level_done: cover property ($fell(trigger_oe_out) && lvl_run_ff);
  c_sample:     cover property (sample_strobe_out);
  c_filt_trig:  cover property (ext_start_trigger_output && ctrl_ff[`ECTL_CTRL_FILT_EN]);
endmodule : ectl_top
`default_nettype wire

// ===== testbench/ectl_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ectl_far_end #(
  parameter int HALF = 640
) (
  input  wire logic       mclk_in,
  input  wire logic       go_in,
  input  wire logic [3:0] pulses_in,
  input  wire logic       trig_lvl_in,
  input  wire logic [2:0] oe_in,
  output var  logic       smpl_out,
  output var  logic       trigger_output,
  output var  logic [2:0] pin_out
);
  logic [4:0] left_ff = 5'h00;
  int         cnt_ff  = 0;
  // ----------------------------------------
  // pins of the external controller
  // ----------------------------------------
  // pull-ups: a line reads high unless the device sinks it
  assign pin_out  = ~oe_in;
  assign trigger_output = trig_lvl_in;
  // 640 cycles a level is 2.56 us, so at most about 195 kHz
  assign smpl_out = ~left_ff[0];
  always @(posedge mclk_in) begin
    if (go_in) begin
      left_ff <= {pulses_in, 1'b0};
      cnt_ff  <= 0;
    end else if (left_ff != 5'h00) begin
      if (cnt_ff == HALF - 1) begin
        cnt_ff  <= 0;
        left_ff <= left_ff - 5'h01;
      end else begin
        cnt_ff <= cnt_ff + 1;
      end
    end
  end
endmodule : ectl_far_end
`default_nettype wire

// ===== testbench/external_control_terminal_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %0h not %0h", $time, g, e); end end
module external_control_terminal_logic_bench;
  logic        mclk  = 1'b0;
  logic        nrst  = 1'b0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        go    = 1'b0;
  logic        tlvl  = 1'b1;
  logic [3:0]  npul  = 4'h0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [8:0]  cond  = 9'h000;
  logic [31:0] rv;
  wire  [31:0] rdata;
  wire  [2:0]  oe, pin, dat;
  wire         smpl, tpin, strobe, active, calmon, st, sp;
  int          num_errors = 0;
  int          total_checks = 0;
  int          n_str = 0, n_start = 0, n_stop = 0, w, a, b;
  logic [31:0] sp_v [4] = '{32'h9, 32'h3E8, 32'h3E9, 32'hA};
  logic [31:0] sp_e [4] = '{32'h64, 32'h3E8, 32'h3E8, 32'hA};
  logic [8:0]  m_c [4] = '{9'h003, 9'h004, 9'h008, 9'h010};

  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    n_str   += int'(strobe);
    n_start += int'(st);
    n_stop  += int'(sp);
  end

  ectl_far_end #(.HALF(640)) ectl_far_end_i (.mclk_in(mclk), .go_in(go), .pulses_in(npul),
    .trig_lvl_in(tlvl), .oe_in(oe), .smpl_out(smpl), .trigger_output(tpin), .pin_out(pin));
  ectl_top #(.TPULSE_CYC(20'h00014), .FILT_CYC(20'h00010)) ectl_top_i (
    .mclk_in(mclk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .judge_valid_in(cond[0]), .judge_pass_in(cond[1]), .error_in(cond[2]),
    .busy_in(cond[3]), .armed_in(cond[4]), .acq_active_in(cond[5]), .trig_event_in(cond[6]),
    .autorange_trig_in(cond[7]), .realtime_save_in(cond[8]), .pass_status_in(pin[0]),
    .pass_status_out(dat[0]), .pass_status_oe_out(oe[0]), .fail_status_in(pin[1]),
    .fail_status_out(dat[1]), .fail_status_oe_out(oe[1]), .trigger_in(pin[2]), .trigger_out(dat[2]),
    .trigger_oe_out(oe[2]), .external_sample_clock_input_in(smpl), .external_trigger_input_in(tpin),
    .sample_strobe_out(strobe), .ext_sample_active_out(active), .calc_monitor_en_out(calmon),
    .ext_start_trigger_output(st), .ext_stop_trigger_output(sp));

  // ----------------------------------------
  // register bus and stimulus tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
    addr <= ad; wdata <= d; wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] ad);
    addr <= ad; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    rv = rdata;
    @(posedge mclk);
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_cyc
  task automatic fire(input int bt);
    w = 0;
    cond[bt] <= 1'b1;
    @(posedge mclk);
    cond[bt] <= 1'b0;
    // look mid-cycle so the first low cycle of the output is counted too
    repeat (3000) begin
      @(negedge mclk);
      if (oe[2]) w++;
      else if (w > 0) break;
    end
    @(posedge mclk);
  endtask : fire
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial begin
    wait_cyc(60000);
    num_errors++;
    complete_run();
  end

  initial begin
    wait_cyc(6);
    nrst <= 1'b1;
    @(posedge mclk);
    rd_reg(8'h00); `CHK(rv, 32'h0)
    rd_reg(8'h04); `CHK(rv, 32'h64)
    rd_reg(8'h10); `CHK(rv, 32'h0)
    `CHK(calmon, 1'b1)
    foreach (sp_v[i]) begin
      wr_reg(8'h04, sp_v[i]);
      rd_reg(8'h04); `CHK(rv, sp_e[i])
      rd_reg(8'h08); `CHK(rv[8], sp_e[i] != sp_v[i])
      wr_reg(8'h08, 32'h100);
    end
    $display("test reset and spdiv done");
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h00, 32'(m) * 32'h140);
      cond <= 9'h000; wait_cyc(3); `CHK(pin[1:0], 2'b11)
      cond <= m_c[m]; wait_cyc(3); `CHK(pin[1:0], (m == 0) ? 2'b10 : 2'b00)
      if (m == 0) begin
        cond <= 9'h001; wait_cyc(3); `CHK(pin[1:0], 2'b01)
      end
    end
    cond <= 9'h100;
    $display("test status outputs done");
    wr_reg(8'h00, 32'h1);
    rd_reg(8'h00); `CHK(rv[0], 1'b0)
    rd_reg(8'h08); `CHK(rv[9], 1'b1)
    cond <= 9'h000;
    wr_reg(8'h08, 32'h200);
    wr_reg(8'h0C, 32'h0);
    wr_reg(8'h00, 32'h1);
    wait_cyc(3); `CHK({active, calmon}, 2'b10)
    for (int r = 0; r < 2; r++) begin
      wr_reg(8'h00, r ? 32'h3 : 32'h1);
      wr_reg(8'h0C, 32'h0);
      a = n_str; npul <= 4'(3 - r); go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0; wait_cyc(4000);
      `CHK(n_str - a, 3 - r)
      rd_reg(8'h0C); `CHK(rv, 32'(3 - r))
    end
    $display("test sampling done");
    wr_reg(8'h00, 32'h0);
    fire(6); `CHK(w inside {21, 22}, 1'b1)
    fire(7); `CHK(w inside {21, 22}, 1'b1)
    wr_reg(8'h00, 32'h4);
    fire(6); `CHK(w inside {[499:505]}, 1'b1)
    cond <= 9'h020;
    wait_cyc(1);
    fork
      fire(6);
      begin wait_cyc(700); cond[5] <= 1'b0; end
    join
    `CHK(w inside {[698:705]}, 1'b1)
    `CHK(dat, 3'b000)
    $display("test trigger output done");
    wr_reg(8'h00, 32'h0);
    tlvl <= 1'b0; wait_cyc(40); a = n_start; b = n_stop;
    tlvl <= 1'b1; wait_cyc(40); `CHK({n_start - a, n_stop - b}, {32'h00000001, 32'h00000000})
    wr_reg(8'h00, 32'h30);
    tlvl <= 1'b0; wait_cyc(40); `CHK({n_start - a, n_stop - b}, {32'h00000001, 32'h00000001})
    wr_reg(8'h00, 32'h8);
    a = n_start;
    tlvl <= 1'b1; wait_cyc(5);
    tlvl <= 1'b0; wait_cyc(40); `CHK(n_start - a, 0)
    tlvl <= 1'b1; wait_cyc(40); `CHK(n_start - a, 1)
    $display("test trigger input done");
    complete_run();
  end
endmodule : external_control_terminal_logic_bench
`default_nettype wire
